// ==== eif_params.svh ====
`ifndef EIF_PARAMS_SVH
`define EIF_PARAMS_SVH

// Register byte offsets
`define EIF_OFS_MODE_A 8'h00
`define EIF_OFS_MODE_B 8'h04
`define EIF_OFS_MODE_C 8'h08
`define EIF_OFS_MODE_D 8'h0C
`define EIF_OFS_WKP_MODE 8'h10
`define EIF_OFS_EDGE 8'h14
`define EIF_OFS_EC_EDGE 8'h18
`define EIF_OFS_IRQ_REQ 8'h1C
`define EIF_OFS_WKP_REQ 8'h20
`define EIF_OFS_IRQ_MASK 8'h24
`define EIF_OFS_WKP_MASK 8'h28
`define EIF_OFS_WKP_EDGE 8'h2C

// Bit positions in the request, mask, edge and mode registers
`define EIF_BIT_IN0 0
`define EIF_BIT_IN1 1
`define EIF_BIT_EC 2
`define EIF_BIT_IN3 3
`define EIF_BIT_IN4 4

// Event counter edge register fields
`define EIF_BIT_EC_SEL_LO 0
`define EIF_BIT_EC_SEL_HI 1
`define EIF_BIT_EC_PWM 2

// Writable bit masks
`define EIF_WMASK_MODE_AB 5'h10
`define EIF_WMASK_MODE_CD 5'h0B
`define EIF_WMASK_EDGE 5'h1B
`define EIF_WMASK_EC_EDGE 3'h7
`define EIF_WMASK_IRQ 5'h1F

// Reset values
`define EIF_RST_EDGE 5'h04
`define EIF_RST_MODE 5'h00
`define EIF_RST_WKP 8'h00
`define EIF_RST_EC_EDGE 3'h0
`define EIF_RST_IRQ 5'h00

// Synchroniser idle level: inactive high
`define EIF_PIN_IDLE 1'b1

`endif

// ==== eif_pkg.sv ====
package eif_pkg;
    typedef logic [4:0] eif_irq_vec_t;
    typedef logic [7:0] eif_wkp_vec_t;
    // Event counter edge choice, {hi, lo}
    typedef enum logic [1:0] {
        EIF_EC_FALL = 2'h0,
        EIF_EC_RISE = 2'h1,
        EIF_EC_BOTH = 2'h2,
        EIF_EC_BOTH_ALT = 2'h3
    } eif_ec_edge_t;
endpackage

// ==== eif_pin_sync.sv ====
`timescale 1ns/1ps
`include "eif_params.svh"

module eif_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous pin in, settled level out
    input wire logic pin,
    output logic level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= `EIF_PIN_IDLE;
            s2_r <= `EIF_PIN_IDLE;
            s3_r <= `EIF_PIN_IDLE;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Change accepted once the last two stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= `EIF_PIN_IDLE;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end

    assign level = level_r;
endmodule

// ==== eif_flag_ctrl.sv ====
`timescale 1ns/1ps
`include "eif_params.svh"

// How it works
// RULE1: Selecting an interrupt pin's function while the pin is low with falling edge chosen sets its flag.
// RULE2: Deselecting an interrupt pin's function while the pin is low with rising edge chosen sets its flag.
// RULE3: The four edge-selectable inputs are selected by either of two mode registers, and a change in either counts.
// RULE4: Selecting a wakeup pin's function while that pin is low sets its wakeup flag; here only while its wakeup edge bit is 0 (falling).
// RULE5: Switching the event counter source sets its flag when the jump between sources matches the chosen edge.
// RULE6: With falling edge chosen, leaving PWM for a low pin while PWM is high sets the event counter flag.
// RULE7: Software clears the affected flag after every function or source change to drop false requests.
// RULE8: An edge-select bit of 0 picks falling edges and 1 picks rising edges.
// RULE9: The event counter input detects rising, falling or both edges per its two select bits.
// RULE10: A flag clear issued as the very next access after a mode or source write is ignored.
// RULE11: A deselected interrupt input shows an inactive high level to its edge detector.

module eif_flag_ctrl
    import eif_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Interrupt pins
    input wire logic EXT_IRQ_IN0,
    input wire logic EXT_IRQ_IN1,
    input wire logic EXT_IRQ_IN3,
    input wire logic EXT_IRQ_IN4,
    input wire logic [7:0] WAKEUP_PIN,
    input wire logic EVENT_COUNTER_IRQ_INPUT,
    // Internal PWM from the event counter, same clock
    input wire logic EVENT_COUNTER_PWM_SIGNAL,
    // Interrupt output
    output logic IRQ
);
    eif_irq_vec_t port_mode_reg_a_r;
    eif_irq_vec_t port_mode_reg_b_r;
    eif_irq_vec_t port_mode_reg_c_r;
    eif_irq_vec_t port_mode_reg_d_r;
    eif_wkp_vec_t wakeup_port_mode_reg_r;
    eif_irq_vec_t irq_edge_select_reg_r;
    eif_wkp_vec_t wakeup_edge_reg_r;
    logic [2:0] event_counter_edge_reg_r;
    eif_irq_vec_t irq_request_reg_one_r;
    eif_irq_vec_t irq_request_reg_one_nxt;
    eif_wkp_vec_t wakeup_request_reg_r;
    eif_wkp_vec_t wakeup_request_reg_nxt;
    eif_irq_vec_t irq_mask_r;
    eif_wkp_vec_t wkp_mask_r;
    logic clr_hold_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    logic wr_en;
    logic rd_setup;
    logic acc_done;
    logic mode_wr;
    logic addr_ok;
    logic [31:0] rd_mux;

    // Synchronised pin levels: irq bits 0,1,3,4 and event counter in bit 2
    logic [4:0] irq_pins;
    logic [4:0] irq_lvl;
    eif_wkp_vec_t wkp_lvl;

    eif_irq_vec_t irq_sel;
    eif_irq_vec_t irq_eff;
    eif_irq_vec_t irq_prev_r;
    eif_irq_vec_t irq_set;
    eif_wkp_vec_t wkp_eff;
    eif_wkp_vec_t wkp_prev_r;
    eif_wkp_vec_t wkp_set;
    eif_ec_edge_t ec_edge;
    logic ec_rise;
    logic ec_fall;

    assign irq_pins = {EXT_IRQ_IN4, EXT_IRQ_IN3, EVENT_COUNTER_IRQ_INPUT, EXT_IRQ_IN1, EXT_IRQ_IN0};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_irq_sync
            eif_pin_sync u_sync (
                .clk(CLK),
                .rst_n(RESET_N),
                .pin(irq_pins[gi]),
                .level(irq_lvl[gi])
            );
        end
        for (gi = 0; gi < 8; gi++) begin : g_wkp_sync
            eif_pin_sync u_sync (
                .clk(CLK),
                .rst_n(RESET_N),
                .pin(WAKEUP_PIN[gi]),
                .level(wkp_lvl[gi])
            );
        end
    endgenerate

    // Bus decode; zero wait states
    assign PREADY = 1'b1;
    assign wr_en = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE;
    assign acc_done = PSEL & PENABLE;
    assign mode_wr = wr_en & ((PADDR == `EIF_OFS_MODE_A) | (PADDR == `EIF_OFS_MODE_B) |
                              (PADDR == `EIF_OFS_MODE_C) | (PADDR == `EIF_OFS_MODE_D) |
                              (PADDR == `EIF_OFS_WKP_MODE) | (PADDR == `EIF_OFS_EC_EDGE));

    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (PADDR)
            `EIF_OFS_MODE_A: rd_mux[4:0] = port_mode_reg_a_r;
            `EIF_OFS_MODE_B: rd_mux[4:0] = port_mode_reg_b_r;
            `EIF_OFS_MODE_C: rd_mux[4:0] = port_mode_reg_c_r;
            `EIF_OFS_MODE_D: rd_mux[4:0] = port_mode_reg_d_r;
            `EIF_OFS_WKP_MODE: rd_mux[7:0] = wakeup_port_mode_reg_r;
            `EIF_OFS_EDGE: rd_mux[4:0] = irq_edge_select_reg_r;
            `EIF_OFS_EC_EDGE: rd_mux[2:0] = event_counter_edge_reg_r;
            `EIF_OFS_IRQ_REQ: rd_mux[4:0] = irq_request_reg_one_r;
            `EIF_OFS_WKP_REQ: rd_mux[7:0] = wakeup_request_reg_r;
            `EIF_OFS_IRQ_MASK: rd_mux[4:0] = irq_mask_r;
            `EIF_OFS_WKP_MASK: rd_mux[7:0] = wkp_mask_r;
            `EIF_OFS_WKP_EDGE: rd_mux[7:0] = wakeup_edge_reg_r;
            default: addr_ok = 1'b0;
        endcase
    end

    // Answer is prepared in the setup cycle so it leaves a flop
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (rd_setup) begin
            prdata_r <= PWRITE ? 32'h0000_0000 : rd_mux;
            pslverr_r <= ~addr_ok;
        end
    end

    assign PRDATA = prdata_r;
    assign PSLVERR = pslverr_r & PSEL & PENABLE;

    // Control registers
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            port_mode_reg_a_r <= `EIF_RST_MODE;
            port_mode_reg_b_r <= `EIF_RST_MODE;
            port_mode_reg_c_r <= `EIF_RST_MODE;
            port_mode_reg_d_r <= `EIF_RST_MODE;
            wakeup_port_mode_reg_r <= `EIF_RST_WKP;
            irq_edge_select_reg_r <= `EIF_RST_EDGE;
            wakeup_edge_reg_r <= `EIF_RST_WKP;
            event_counter_edge_reg_r <= `EIF_RST_EC_EDGE;
            irq_mask_r <= `EIF_RST_IRQ;
            wkp_mask_r <= `EIF_RST_WKP;
        end else if (wr_en) begin
            case (PADDR)
                `EIF_OFS_MODE_A: port_mode_reg_a_r <= PWDATA[4:0] & `EIF_WMASK_MODE_AB;
                `EIF_OFS_MODE_B: port_mode_reg_b_r <= PWDATA[4:0] & `EIF_WMASK_MODE_AB;
                `EIF_OFS_MODE_C: port_mode_reg_c_r <= PWDATA[4:0] & `EIF_WMASK_MODE_CD;
                `EIF_OFS_MODE_D: port_mode_reg_d_r <= PWDATA[4:0] & `EIF_WMASK_MODE_CD;
                `EIF_OFS_WKP_MODE: wakeup_port_mode_reg_r <= PWDATA[7:0];
                // Reserved bit 2 always reads one
                `EIF_OFS_EDGE: irq_edge_select_reg_r <= (PWDATA[4:0] & `EIF_WMASK_EDGE) | `EIF_RST_EDGE;
                `EIF_OFS_EC_EDGE: event_counter_edge_reg_r <= PWDATA[2:0] & `EIF_WMASK_EC_EDGE;
                `EIF_OFS_IRQ_MASK: irq_mask_r <= PWDATA[4:0] & `EIF_WMASK_IRQ;
                `EIF_OFS_WKP_MASK: wkp_mask_r <= PWDATA[7:0];
                `EIF_OFS_WKP_EDGE: wakeup_edge_reg_r <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // Either mode register selects the pin function
    assign irq_sel = port_mode_reg_a_r | port_mode_reg_b_r | port_mode_reg_c_r | port_mode_reg_d_r; // RULE3

    // Deselected input parks high, so a switch looks like an edge
    always_comb begin
        irq_eff = {irq_sel[4] ? irq_lvl[4] : 1'b1,
                   irq_sel[3] ? irq_lvl[3] : 1'b1,
                   1'b1,
                   irq_sel[1] ? irq_lvl[1] : 1'b1,
                   irq_sel[0] ? irq_lvl[0] : 1'b1}; // RULE11
        // Source bit set takes the pin, clear takes the PWM
        irq_eff[`EIF_BIT_EC] = event_counter_edge_reg_r[`EIF_BIT_EC_PWM] ?
                               irq_lvl[`EIF_BIT_EC] : EVENT_COUNTER_PWM_SIGNAL; // RULE5 RULE6
    end

    assign wkp_eff = ~wakeup_port_mode_reg_r | wkp_lvl; // RULE11

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_prev_r <= 5'h1F;
            wkp_prev_r <= 8'hFF;
        end else begin
            irq_prev_r <= irq_eff;
            wkp_prev_r <= wkp_eff;
        end
    end

    // Edge on the effective level, whether from the pin or from a switch
    always_comb begin
        irq_set = '0;
        for (int i = 0; i < 5; i++) begin
            if (i != `EIF_BIT_EC) begin
                irq_set[i] = irq_edge_select_reg_r[i] ?
                             (irq_eff[i] & ~irq_prev_r[i]) : // RULE2 RULE8
                             (~irq_eff[i] & irq_prev_r[i]); // RULE1 RULE8
            end
        end
        irq_set[`EIF_BIT_EC] = (ec_edge == EIF_EC_RISE) ? ec_rise :
                               (ec_edge == EIF_EC_FALL) ? ec_fall : (ec_rise | ec_fall); // RULE9 RULE6
    end

    assign ec_edge = eif_ec_edge_t'({event_counter_edge_reg_r[`EIF_BIT_EC_SEL_HI],
                                     event_counter_edge_reg_r[`EIF_BIT_EC_SEL_LO]});
    assign ec_rise = irq_eff[`EIF_BIT_EC] & ~irq_prev_r[`EIF_BIT_EC];
    assign ec_fall = ~irq_eff[`EIF_BIT_EC] & irq_prev_r[`EIF_BIT_EC];

    assign wkp_set = (wakeup_edge_reg_r & wkp_eff & ~wkp_prev_r) |
                     (~wakeup_edge_reg_r & ~wkp_eff & wkp_prev_r); // RULE4

    // A clear right behind a mode write is dropped; any other access rearms
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            clr_hold_r <= 1'b0;
        end else if (acc_done) begin
            clr_hold_r <= mode_wr; // RULE10
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_comb begin
        irq_request_reg_one_nxt = irq_request_reg_one_r;
        wakeup_request_reg_nxt = wakeup_request_reg_r;
        if (wr_en && !clr_hold_r) begin // RULE10 RULE7
            if (PADDR == `EIF_OFS_IRQ_REQ) begin
                irq_request_reg_one_nxt = irq_request_reg_one_r & ~PWDATA[4:0];
            end
            if (PADDR == `EIF_OFS_WKP_REQ) begin
                wakeup_request_reg_nxt = wakeup_request_reg_r & ~PWDATA[7:0];
            end
        end
        irq_request_reg_one_nxt = irq_request_reg_one_nxt | irq_set;
        wakeup_request_reg_nxt = wakeup_request_reg_nxt | wkp_set;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_request_reg_one_r <= `EIF_RST_IRQ;
            wakeup_request_reg_r <= `EIF_RST_WKP;
        end else begin
            irq_request_reg_one_r <= irq_request_reg_one_nxt;
            wakeup_request_reg_r <= wakeup_request_reg_nxt;
        end
    end

    // Mask bit one lets the flag through
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_request_reg_one_nxt & irq_mask_r) | |(wakeup_request_reg_nxt & wkp_mask_r);
        end
    end
endmodule

// ==== eif_pin_model.sv ====
`timescale 1ns/1ps
module eif_pin_model (
    // Clock
    input wire logic CLK,
    // Wanted levels {pwm, ec, wakeup[7:0], irq[3:0]}
    input wire logic [13:0] want,
    // Levels at the pins
    output logic [3:0] irq_pin,
    output logic [7:0] wkp_pin,
    output logic ec_pin,
    output logic pwm
);
    initial {pwm, ec_pin, wkp_pin, irq_pin} = 14'h3FFF;
    // Moves only after an edge, never mid-cycle
    always @(posedge CLK) begin
        {pwm, ec_pin, wkp_pin, irq_pin} <= want;
    end
endmodule

// ==== eif_flag_ctrl_checker.sv ====
`timescale 1ns/1ps
module eif_flag_ctrl_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Interrupt
    input wire logic IRQ
);
    logic mapped;
    logic irq_mz_r;
    logic wkp_mz_r;
    assign mapped = PADDR[1:0] == 2'h0 && PADDR <= 8'h2C;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_wr_acc; PSEL && PENABLE && PWRITE; endsequence
    sequence s_rd_acc; PSEL && PENABLE && !PWRITE; endsequence
    // Mask mirrors: both zero means nothing may reach IRQ
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_mz_r <= 1'b1;
            wkp_mz_r <= 1'b1;
        end else if (PSEL && PENABLE && PWRITE) begin
            if (PADDR == 8'h24) irq_mz_r <= PWDATA[4:0] == 5'h00;
            if (PADDR == 8'h28) wkp_mz_r <= PWDATA[7:0] == 8'h00;
        end
    end
    a_ready_high: assert property (PREADY)
        else $error("ready dropped");
    a_err_unmapped: assert property (PSEL && PENABLE && !mapped |-> PSLVERR)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (PSEL && PENABLE && mapped |-> !PSLVERR)
        else $error("mapped access refused");
    a_err_outside: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
        else $error("error outside access phase");
    a_wr_data_zero: assert property (s_wr_acc |-> PRDATA == 32'h0)
        else $error("read data not zero on write");
    a_rd_data_hold: assert property (s_rd_acc |=> $stable(PRDATA))
        else $error("read data moved after access");
    a_edge_fixed_bit: assert property ((s_rd_acc ##0 PADDR == 8'h14) |-> PRDATA[31:2] == 30'h1 || PRDATA[31:2] == 30'h3 ||
        PRDATA[31:2] == 30'h5 || PRDATA[31:2] == 30'h7)
        else $error("edge register fixed bits wrong");
    a_mask_quiet: assert property ((irq_mz_r && wkp_mz_r) [*2] |-> !IRQ)
        else $error("irq while all masked");
endmodule
bind eif_flag_ctrl eif_flag_ctrl_checker u_chk (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ(IRQ));

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, ec_pin, pwm;
    logic [7:0] paddr, wkp_pin;
    logic [31:0] pwdata, prdata, f;
    logic [13:0] want;
    logic [3:0] irq_pin;
    logic [32:0] exp_q[$];
    integer err_count, checked, seed, r, o, b, e;
    eif_pin_model pins (.CLK(clk), .want(want), .irq_pin(irq_pin), .wkp_pin(wkp_pin), .ec_pin(ec_pin), .pwm(pwm));
    eif_flag_ctrl dut (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXT_IRQ_IN0(irq_pin[0]), .EXT_IRQ_IN1(irq_pin[1]), .EXT_IRQ_IN3(irq_pin[2]), .EXT_IRQ_IN4(irq_pin[3]),
        .WAKEUP_PIN(wkp_pin), .EVENT_COUNTER_IRQ_INPUT(ec_pin), .EVENT_COUNTER_PWM_SIGNAL(pwm), .IRQ(irq));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("errors=%0d checks=%0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            err_count++;
            complete_run;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        exp_q.push_back({1'b0, d});
        apb(1'b0, a, 32'h0);
    endtask
    // Mode write plus room for the flag to land
    task automatic sw(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
            if (exp_q.size() == 0) check(33'h0, 33'h1);
            else check({pslverr, pslverr ? 32'h0 : prdata}, exp_q.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        err_count++;
        complete_run;
    end
    initial begin
        seed = 32'hEF31F5FA;
        err_count = 0;
        checked = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        want = 14'h3FFF;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h14, 32'h4);
        rd(8'h1C, 32'h0);
        rd(8'h20, 32'h0);
        exp_q.push_back({1'b1, 32'h0});
        apb(1'b0, 8'h30, 32'h0);
        // All pins low, PWM high; pins stay masked until selected
        want <= 14'h2000;
        repeat (10) @(posedge clk);
        for (o = 0; o < 16; o += 4)
            for (b = 0; b < 5; b++)
                if (((o < 8 ? 5'h10 : 5'h0B) >> b) & 5'h01) begin
                    f = 32'h1 << b;
                    wr(8'h14, 32'h0);
                    sw(o[7:0], f);
                    wr(8'h1C, 32'h1F);
                    rd(8'h1C, f);
                    wr(8'h1C, 32'h1F);
                    sw(o[7:0], 32'h0);
                    rd(8'h1C, 32'h0);
                    wr(8'h14, 32'h1B);
                    sw(o[7:0], f);
                    rd(8'h1C, 32'h0);
                    sw(o[7:0], 32'h0);
                    rd(8'h1C, f);
                    wr(8'h1C, 32'h1F);
                end
        wr(8'h28, 32'hFF);
        r = $random(seed);
        sw(8'h10, r[7:0]);
        rd(8'h20, {24'h0, r[7:0]});
        repeat (2) @(posedge clk);
        check({32'h0, irq}, {32'h0, r[7:0] != 8'h00});
        wr(8'h28, 32'h0);
        repeat (2) @(posedge clk);
        check({32'h0, irq}, 33'h0);
        wr(8'h20, 32'hFF);
        sw(8'h10, 32'h0);
        rd(8'h20, 32'h0);
        for (e = 0; e < 3; e++) begin
            wr(8'h18, e);
            sw(8'h18, e | 4);
            rd(8'h1C, e != 1 ? 32'h4 : 32'h0);
            wr(8'h1C, 32'h1F);
            sw(8'h18, e);
            rd(8'h1C, e != 0 ? 32'h4 : 32'h0);
            wr(8'h1C, 32'h1F);
        end
        // Unmasked flag drives IRQ; an early clear leaves it standing
        wr(8'h24, 32'h1F);
        sw(8'h18, 32'h6);
        check({32'h0, irq}, 33'h1);
        wr(8'h1C, 32'h1F);
        repeat (2) @(posedge clk);
        check({32'h0, irq}, 33'h1);
        wr(8'h1C, 32'h1F);
        repeat (2) @(posedge clk);
        check({32'h0, irq}, 33'h0);
        complete_run;
    end
endmodule
